// >>> prfc_pkg.sv
// prfc_pkg: offsets, field positions, reset values and codes of the pll reference/feedback config
// assumes a byte-wide management port with 16-bit register addresses
package prfc_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int PRE_W = 21;
  localparam int FB_W = 24;

  // byte offsets
  localparam logic [15:0] ADDR_REF_MODE = 16'h0008;
  localparam logic [15:0] ADDR_PRIORITY = 16'h0009;
  localparam logic [15:0] ADDR_EXCL_STATE = 16'h000a;
  localparam logic [15:0] ADDR_PRE0_HI = 16'h000b;
  localparam logic [15:0] ADDR_PRE0_MID = 16'h000c;
  localparam logic [15:0] ADDR_PRE0_LO = 16'h000d;
  localparam logic [15:0] ADDR_PRE1_HI = 16'h000e;
  localparam logic [15:0] ADDR_PRE1_MID = 16'h000f;
  localparam logic [15:0] ADDR_PRE1_LO = 16'h0010;
  localparam logic [15:0] ADDR_FB0_HI = 16'h0017;
  localparam logic [15:0] ADDR_FB0_MID = 16'h0018;
  localparam logic [15:0] ADDR_FB0_LO = 16'h0019;
  localparam logic [15:0] ADDR_FB1_HI = 16'h001a;
  localparam logic [15:0] ADDR_FB1_MID = 16'h001b;
  localparam logic [15:0] ADDR_FB1_LO = 16'h001c;
  localparam logic [15:0] ADDR_LOOP_BW = 16'h0023;
  localparam logic [15:0] ADDR_LOOP_DAMP = 16'h0024;
  localparam logic [15:0] ADDR_TGL_FILT = 16'h0025;
  localparam logic [15:0] ADDR_TGL_THR = 16'h0028;

  // field positions
  localparam int REF_MODE_LSB = 5;
  localparam int PRI1_LSB = 2;
  localparam int PRI0_LSB = 0;
  localparam int EXCL1_BIT = 5;
  localparam int EXCL0_BIT = 4;
  localparam int OVR_LSB = 0;
  localparam int TGL_THR_LSB = 1;

  // reset values
  localparam logic [2:0] RST_REF_MODE = 3'h0;
  localparam logic [1:0] RST_PRI0 = 2'h0;
  localparam logic [1:0] RST_PRI1 = 2'h1;
  localparam logic RST_EXCL = 1'b0;
  localparam logic [1:0] RST_OVR = 2'h0;
  localparam logic [20:0] RST_PRE = 21'h00_0000;
  localparam logic [23:0] RST_FB = 24'h07_0000;
  localparam logic [7:0] RST_LOOP_BW = 8'h77;
  localparam logic [7:0] RST_LOOP_DAMP = 8'h6c;
  localparam logic [7:0] RST_TGL_FILT = 8'h00;
  localparam logic [6:0] RST_TGL_THR = 7'h00;

  // reference selection mode codes
  localparam logic [2:0] MODE_AUTO = 3'h0;
  localparam logic [2:0] MODE_GPIO = 3'h1;
  localparam logic [2:0] MODE_FORCE0 = 3'h4;
  localparam logic [2:0] MODE_FORCE1 = 3'h5;

  // state override codes
  localparam logic [1:0] OVR_AUTO = 2'h0;
  localparam logic [1:0] OVR_FREE_RUNNING_STATE = 2'h1;
  localparam logic [1:0] OVR_NORMAL = 2'h2;
  localparam logic [1:0] OVR_HOLDOVER = 2'h3;

  typedef enum logic [2:0] {
    PRFC_ST_FREE_RUNNING_STATE = 3'b001,
    PRFC_ST_NORMAL = 3'b010,
    PRFC_ST_HOLDOVER = 3'b100
  } prfc_state_e;

endpackage : prfc_pkg

// >>> prfc_ref_select.sv
// prfc_ref_select: picks the reference the pll follows
// assumes reference health flags are synchronous to mclk
`timescale 1ns/1ns
module prfc_ref_select (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // settings
  input wire logic [2:0] ref_mode,
  input wire logic [1:0] ref0_priority,
  input wire logic [1:0] ref1_priority,
  input wire logic ref0_exclude,
  input wire logic ref1_exclude,
  // reference health
  input wire logic ref0_valid,
  input wire logic ref1_valid,
  input wire logic gpio_ref_select,
  // choice
  output logic sel_ref,
  output logic sel_valid
);
  import prfc_pkg::*;

  logic sel_q, sel_d, valid_q, valid_d;
  logic cand0, cand1;

  always_comb begin
    cand0 = ref0_valid && !ref0_exclude;
    cand1 = ref1_valid && !ref1_exclude;
    sel_d = sel_q;
    valid_d = 1'b0;
    unique case (ref_mode)
      MODE_AUTO: begin
        // excluded references never win, even when healthy
        if (cand0 && cand1) begin
          sel_d = (ref1_priority < ref0_priority); // tie goes to ref0
          valid_d = 1'b1;
        end else if (cand0 || cand1) begin
          sel_d = cand1;
          valid_d = 1'b1;
        end
      end
      MODE_GPIO: begin
        sel_d = gpio_ref_select;
        valid_d = gpio_ref_select ? ref1_valid : ref0_valid;
      end
      MODE_FORCE0: begin
        sel_d = 1'b0;
        valid_d = ref0_valid;
      end
      MODE_FORCE1: begin
        sel_d = 1'b1;
        valid_d = ref1_valid;
      end
      // reserved codes keep the last choice but report no usable input
      default: valid_d = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      sel_q <= sel_d;
      valid_q <= valid_d;
    end
  end

  assign sel_ref = sel_q;
  assign sel_valid = valid_q;
endmodule : prfc_ref_select

// >>> prfc_state_ctrl.sv
// prfc_state_ctrl: free-run / normal / holdover state with software override
// assumes sel_valid is the registered health of the chosen reference
`timescale 1ns/1ns
module prfc_state_ctrl (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // control
  input wire logic [1:0] pll_state_override,
  input wire logic sel_valid,
  // state
  output prfc_pkg::prfc_state_e pll_state,
  output logic state_forced
);
  import prfc_pkg::*;

  prfc_state_e state_q, state_d;
  logic forced_q, forced_d;

  always_comb begin
    state_d = state_q;
    forced_d = (pll_state_override != OVR_AUTO);
    unique case (pll_state_override)
      OVR_FREE_RUNNING_STATE: state_d = PRFC_ST_FREE_RUNNING_STATE;
      OVR_NORMAL: state_d = PRFC_ST_NORMAL;
      OVR_HOLDOVER: state_d = PRFC_ST_HOLDOVER;
      OVR_AUTO: begin
        unique case (state_q)
          PRFC_ST_FREE_RUNNING_STATE: if (sel_valid) state_d = PRFC_ST_NORMAL;
          PRFC_ST_NORMAL: if (!sel_valid) state_d = PRFC_ST_HOLDOVER;
          PRFC_ST_HOLDOVER: if (sel_valid) state_d = PRFC_ST_NORMAL;
          default: state_d = PRFC_ST_FREE_RUNNING_STATE;
        endcase
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= PRFC_ST_FREE_RUNNING_STATE;
      forced_q <= 1'b0;
    end else begin
      state_q <= state_d;
      forced_q <= forced_d;
    end
  end

  assign pll_state = state_q;
  assign state_forced = forced_q;
endmodule : prfc_state_ctrl

// >>> prfc_config_regs.sv
// prfc_config_regs: byte-addressed config bank for the pll reference and feedback paths
// assumes a byte port behind the serial management interface, all on mclk
//
// Function
// - reference 1 priority is 2 bits, resets to 01, 00 is first priority, 10/11 must not be used.
// - reference 0 exclude bit resets to 0 and when set drops reference 0 from automatic choice.
// - reference 1 exclude bit resets to 0 and when set drops reference 1 from automatic choice.
// - state override is 2 bits, resets to 00, and 00 lets the pll state machine run by itself.
// - override 01 forces free-run, 10 forces normal, 11 forces holdover.
// - reference 0 pre-divider is 21 bits, resets to zero, and is applied while reference 0 is used.
// - reference 1 pre-divider is 21 bits, resets to zero, and is applied while reference 1 is used.
// - reserved bits are written as zero by the host and carry no defined read value.
// - each 24-bit feedback divider spans three bytes, high byte first, at 0017 and 001a.
// - byte 0023 holds locked/acquire bandwidth; 0024 holds locked/acquire damping and loop gain.
// - reference 0 priority is 2 bits, resets to 00, 01 is second priority, 10/11 must not be used.
// - priority and exclusion steer the choice only in automatic selection mode 000, the reset mode.
`timescale 1ns/1ns
module prfc_config_regs (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // management byte port
  input wire logic [prfc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [prfc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_rd_en,
  output logic [prfc_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rdata_valid,
  // reference health
  input wire logic ref0_valid,
  input wire logic ref1_valid,
  input wire logic gpio_ref_select,
  // divider ratios
  output logic [prfc_pkg::PRE_W-1:0] ref0_predivider,
  output logic [prfc_pkg::PRE_W-1:0] ref1_predivider,
  output logic [prfc_pkg::FB_W-1:0] ref0_feedback_divider,
  output logic [prfc_pkg::FB_W-1:0] ref1_feedback_divider,
  output logic [prfc_pkg::PRE_W-1:0] active_predivider,
  output logic [prfc_pkg::FB_W-1:0] active_feedback_divider,
  // reference choice and pll state
  output logic selected_ref,
  output logic selected_ref_valid,
  output prfc_pkg::prfc_state_e pll_state,
  output logic state_forced,
  // loop filter settings
  output logic [3:0] locked_bandwidth,
  output logic [3:0] acquire_bandwidth,
  output logic [2:0] locked_damping,
  output logic [2:0] acquire_damping,
  output logic [1:0] loop_gain,
  output logic [2:0] lock_toggle_damping,
  output logic lock_toggle_hysteresis,
  output logic [2:0] lock_toggle_bandwidth,
  output logic [6:0] lock_toggle_threshold
);
  import prfc_pkg::*;

  // reset release through two flops
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) rst_sync_q <= 2'h0;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // stored fields
  logic [2:0] ref_mode_q, ref_mode_d;
  logic [1:0] pri0_q, pri0_d, pri1_q, pri1_d, ovr_q, ovr_d;
  logic excl0_q, excl0_d, excl1_q, excl1_d;
  logic [PRE_W-1:0] pre0_q, pre0_d, pre1_q, pre1_d;
  logic [FB_W-1:0] fb0_q, fb0_d, fb1_q, fb1_d;
  logic [7:0] bw_q, bw_d, damp_q, damp_d;
  logic [6:0] tglf_q, tglf_d, thr_q, thr_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic [PRE_W-1:0] act_pre_q, act_pre_d;
  logic [FB_W-1:0] act_fb_q, act_fb_d;
  logic sel_ref, sel_valid;

  // read-back byte; reserved and unmapped bits read as zero
  function automatic logic [7:0] read_byte(input logic [15:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      ADDR_REF_MODE: v[REF_MODE_LSB +: 3] = ref_mode_q;
      ADDR_PRIORITY: v = {4'h0, pri1_q, pri0_q};
      ADDR_EXCL_STATE: v = {2'h0, excl1_q, excl0_q, 2'h0, ovr_q};
      ADDR_PRE0_HI: v = {3'h0, pre0_q[20:16]};
      ADDR_PRE0_MID: v = pre0_q[15:8];
      ADDR_PRE0_LO: v = pre0_q[7:0];
      ADDR_PRE1_HI: v = {3'h0, pre1_q[20:16]};
      ADDR_PRE1_MID: v = pre1_q[15:8];
      ADDR_PRE1_LO: v = pre1_q[7:0];
      ADDR_FB0_HI: v = fb0_q[23:16];
      ADDR_FB0_MID: v = fb0_q[15:8];
      ADDR_FB0_LO: v = fb0_q[7:0];
      ADDR_FB1_HI: v = fb1_q[23:16];
      ADDR_FB1_MID: v = fb1_q[15:8];
      ADDR_FB1_LO: v = fb1_q[7:0];
      ADDR_LOOP_BW: v = bw_q;
      ADDR_LOOP_DAMP: v = damp_q;
      ADDR_TGL_FILT: v = {tglf_q, 1'b0};
      ADDR_TGL_THR: v = {thr_q, 1'b0};
      default: v = 8'h00;
    endcase
    return v;
  endfunction : read_byte

  // byte writes; reserved bits are dropped, the host writes them as zero
  always_comb begin
    ref_mode_d = ref_mode_q;
    pri0_d = pri0_q;
    pri1_d = pri1_q;
    excl0_d = excl0_q;
    excl1_d = excl1_q;
    ovr_d = ovr_q;
    pre0_d = pre0_q;
    pre1_d = pre1_q;
    fb0_d = fb0_q;
    fb1_d = fb1_q;
    bw_d = bw_q;
    damp_d = damp_q;
    tglf_d = tglf_q;
    thr_d = thr_q;
    if (reg_wr_en) begin
      unique case (reg_addr)
        ADDR_REF_MODE: ref_mode_d = reg_wdata[REF_MODE_LSB +: 3];
        ADDR_PRIORITY: begin
          pri1_d = reg_wdata[PRI1_LSB +: 2];
          pri0_d = reg_wdata[PRI0_LSB +: 2];
        end
        ADDR_EXCL_STATE: begin
          excl1_d = reg_wdata[EXCL1_BIT];
          excl0_d = reg_wdata[EXCL0_BIT];
          ovr_d = reg_wdata[OVR_LSB +: 2];
        end
        ADDR_PRE0_HI: pre0_d[20:16] = reg_wdata[4:0];
        ADDR_PRE0_MID: pre0_d[15:8] = reg_wdata;
        ADDR_PRE0_LO: pre0_d[7:0] = reg_wdata;
        ADDR_PRE1_HI: pre1_d[20:16] = reg_wdata[4:0];
        ADDR_PRE1_MID: pre1_d[15:8] = reg_wdata;
        ADDR_PRE1_LO: pre1_d[7:0] = reg_wdata;
        ADDR_FB0_HI: fb0_d[23:16] = reg_wdata;
        ADDR_FB0_MID: fb0_d[15:8] = reg_wdata;
        ADDR_FB0_LO: fb0_d[7:0] = reg_wdata;
        ADDR_FB1_HI: fb1_d[23:16] = reg_wdata;
        ADDR_FB1_MID: fb1_d[15:8] = reg_wdata;
        ADDR_FB1_LO: fb1_d[7:0] = reg_wdata;
        ADDR_LOOP_BW: bw_d = reg_wdata;
        ADDR_LOOP_DAMP: damp_d = reg_wdata;
        ADDR_TGL_FILT: tglf_d = reg_wdata[7:1];
        ADDR_TGL_THR: thr_d = reg_wdata[TGL_THR_LSB +: 7];
        default: ;
      endcase
    end
  end

  // read port and the ratios handed to the datapath for the chosen reference
  always_comb begin
    rvalid_d = reg_rd_en;
    rdata_d = reg_rd_en ? read_byte(reg_addr) : rdata_q;
    act_pre_d = sel_ref ? pre1_q : pre0_q;
    act_fb_d = sel_ref ? fb1_q : fb0_q;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ref_mode_q <= RST_REF_MODE;
      pri0_q <= RST_PRI0;
      pri1_q <= RST_PRI1;
      excl0_q <= RST_EXCL;
      excl1_q <= RST_EXCL;
      ovr_q <= RST_OVR;
      pre0_q <= RST_PRE;
      pre1_q <= RST_PRE;
      fb0_q <= RST_FB;
      fb1_q <= RST_FB;
      bw_q <= RST_LOOP_BW;
      damp_q <= RST_LOOP_DAMP;
      tglf_q <= RST_TGL_FILT[7:1];
      thr_q <= RST_TGL_THR;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      act_pre_q <= RST_PRE;
      act_fb_q <= RST_FB;
    end else begin
      ref_mode_q <= ref_mode_d;
      pri0_q <= pri0_d;
      pri1_q <= pri1_d;
      excl0_q <= excl0_d;
      excl1_q <= excl1_d;
      ovr_q <= ovr_d;
      pre0_q <= pre0_d;
      pre1_q <= pre1_d;
      fb0_q <= fb0_d;
      fb1_q <= fb1_d;
      bw_q <= bw_d;
      damp_q <= damp_d;
      tglf_q <= tglf_d;
      thr_q <= thr_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      act_pre_q <= act_pre_d;
      act_fb_q <= act_fb_d;
    end
  end

  // reference choice: priority and exclusion only matter in automatic mode
  prfc_ref_select u_ref_select (
    .mclk(mclk),
    .rst_n(rst_n),
    .ref_mode(ref_mode_q),
    .ref0_priority(pri0_q),
    .ref1_priority(pri1_q),
    .ref0_exclude(excl0_q),
    .ref1_exclude(excl1_q),
    .ref0_valid(ref0_valid),
    .ref1_valid(ref1_valid),
    .gpio_ref_select(gpio_ref_select),
    .sel_ref(sel_ref),
    .sel_valid(sel_valid)
  );

  prfc_state_ctrl u_state_ctrl (
    .mclk(mclk),
    .rst_n(rst_n),
    .pll_state_override(ovr_q),
    .sel_valid(sel_valid),
    .pll_state(pll_state),
    .state_forced(state_forced)
  );

  assign reg_rdata = rdata_q;
  assign reg_rdata_valid = rvalid_q;
  assign ref0_predivider = pre0_q;
  assign ref1_predivider = pre1_q;
  assign ref0_feedback_divider = fb0_q;
  assign ref1_feedback_divider = fb1_q;
  assign active_predivider = act_pre_q;
  assign active_feedback_divider = act_fb_q;
  assign selected_ref = sel_ref;
  assign selected_ref_valid = sel_valid;
  assign locked_bandwidth = bw_q[7:4];
  assign acquire_bandwidth = bw_q[3:0];
  assign locked_damping = damp_q[7:5];
  assign acquire_damping = damp_q[4:2];
  assign loop_gain = damp_q[1:0];
  assign lock_toggle_damping = tglf_q[6:4];
  assign lock_toggle_hysteresis = tglf_q[3];
  assign lock_toggle_bandwidth = tglf_q[2:0];
  assign lock_toggle_threshold = thr_q;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_pri1_write: assert property (
    reg_wr_en && reg_addr == ADDR_PRIORITY |=> pri1_q == $past(reg_wdata[3:2]))
    else $error("ref1 priority not taken from write");
  chk_excl0_write: assert property (
    reg_wr_en && reg_addr == ADDR_EXCL_STATE |=> excl0_q == $past(reg_wdata[4]))
    else $error("ref0 exclude not taken from write");
  chk_excl1_block: assert property (
    ref_mode_q == MODE_AUTO && excl1_q |=> !(selected_ref && selected_ref_valid))
    else $error("excluded ref1 was chosen");
  chk_ovr_auto_free: assert property (
    ovr_q == OVR_AUTO |=> !state_forced)
    else $error("state forced while override is auto");
  chk_ovr_holdover: assert property (
    ovr_q == OVR_HOLDOVER |=> pll_state == PRFC_ST_HOLDOVER && state_forced)
    else $error("holdover override not applied");
  chk_pre0_apply: assert property (
    !selected_ref |=> active_predivider == $past(pre0_q))
    else $error("ref0 pre-divider not applied");
  chk_pre1_apply: assert property (
    selected_ref |=> active_predivider == $past(pre1_q) && active_feedback_divider == $past(fb1_q))
    else $error("ref1 dividers not applied");
  chk_rsvd_read: assert property (
    reg_rd_en && reg_addr == ADDR_PRE1_HI |=> reg_rdata[7:5] == 3'h0)
    else $error("reserved bits read nonzero");
  chk_fb_byte_order: assert property (
    reg_rd_en && reg_addr == ADDR_FB0_HI |=> reg_rdata == $past(fb0_q[23:16]))
    else $error("feedback high byte misplaced");
  chk_bw_fields: assert property (
    reg_wr_en && reg_addr == ADDR_LOOP_BW
    |=> locked_bandwidth == $past(reg_wdata[7:4]) && acquire_bandwidth == $past(reg_wdata[3:0]))
    else $error("bandwidth nibbles misplaced");
  chk_pri0_write: assert property (
    reg_wr_en && reg_addr == ADDR_PRIORITY |=> pri0_q == $past(reg_wdata[1:0]))
    else $error("ref0 priority not taken from write");
  chk_force_mode: assert property (
    ref_mode_q == MODE_FORCE0 && excl0_q |=> !selected_ref && selected_ref_valid == $past(ref0_valid))
    else $error("forced mode not obeyed");
  chk_auto_priority: assert property (
    ref_mode_q == MODE_AUTO && ref0_valid && ref1_valid && !excl0_q && !excl1_q
    && pri1_q < pri0_q |=> selected_ref && selected_ref_valid)
    else $error("better priority not chosen");
  chk_read_answer: assert property (
    reg_rd_en |=> reg_rdata_valid ##1 (reg_rdata_valid == $past(reg_rd_en)))
    else $error("read answer timing wrong");

  cov_forced_holdover: cover property (ovr_q == OVR_HOLDOVER ##1 pll_state == PRFC_ST_HOLDOVER);
  cov_auto_to_ref1: cover property (ref_mode_q == MODE_AUTO && !selected_ref ##1 selected_ref);
  cov_write_read: cover property (reg_wr_en ##2 reg_rd_en ##1 reg_rdata_valid);
  cov_holdover_auto: cover property (pll_state == PRFC_ST_NORMAL ##1 pll_state == PRFC_ST_HOLDOVER);
endmodule : prfc_config_regs

// >>> prfc_host_model.sv
// prfc_host_model: management-port host that writes and reads single bytes
// assumes the bench calls its tasks; requests change only just after a rising mclk edge
`timescale 1ns/1ns
module prfc_host_model (
  // clock
  input wire logic mclk,
  // byte port towards the bank
  output logic [prfc_pkg::ADDR_W-1:0] reg_addr,
  output logic reg_wr_en,
  output logic [prfc_pkg::DATA_W-1:0] reg_wdata,
  output logic reg_rd_en,
  input wire logic [prfc_pkg::DATA_W-1:0] reg_rdata,
  input wire logic reg_rdata_valid
);
  import prfc_pkg::*;

  initial begin
    reg_addr = 16'hffff;
    reg_wr_en = 1'b0;
    reg_wdata = 8'ha5;
    reg_rd_en = 1'b0;
  end

  // keep masks the byte so reserved positions go out as zero while the write strobe is high
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] keep);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d & keep;
    reg_wr_en <= 1'b1;
    @(posedge mclk);
    reg_wr_en <= 1'b0;
    // released lines show garbage, not the last value
    reg_addr <= ~a;
    reg_wdata <= ~(d & keep);
  endtask : wr

  // read data is taken one cycle after the strobe edge, where it stands
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge mclk);
    reg_rd_en <= 1'b0;
    reg_addr <= ~a;
    #1;
    ok = reg_rdata_valid;
    d = reg_rdata;
  endtask : rd
endmodule : prfc_host_model

// >>> prfc_config_regs_tb.sv
// prfc_config_regs_tb: self-checking bench for the pll reference/feedback config bank
// assumes the host model owns the byte port; bench drives reference health at mclk edges
`timescale 1ns/1ns
module prfc_config_regs_tb;
  import prfc_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic ref0_valid = 1'b0;
  logic ref1_valid = 1'b0;
  logic gpio_ref_select = 1'b0;
  logic [15:0] reg_addr;
  logic reg_wr_en;
  logic [7:0] reg_wdata;
  logic reg_rd_en;
  logic [7:0] reg_rdata;
  logic reg_rdata_valid;
  logic [20:0] ref0_predivider, ref1_predivider, active_predivider;
  logic [23:0] ref0_feedback_divider, ref1_feedback_divider, active_feedback_divider;
  logic selected_ref, selected_ref_valid, state_forced, lock_toggle_hysteresis;
  prfc_state_e pll_state;
  logic [3:0] locked_bandwidth, acquire_bandwidth;
  logic [2:0] locked_damping, acquire_damping, lock_toggle_damping, lock_toggle_bandwidth;
  logic [1:0] loop_gain;
  logic [6:0] lock_toggle_threshold;
  int n_mismatch = 0;
  int n_tests = 0;
  localparam logic [23:0] FB0 = 24'ha5_3c01;
  localparam logic [23:0] FB1 = 24'h00_ff80;

  always #5 mclk = ~mclk;

  prfc_host_model u_host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid));

  prfc_config_regs DUT (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
    .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid), .ref0_valid(ref0_valid),
    .ref1_valid(ref1_valid), .gpio_ref_select(gpio_ref_select),
    .ref0_predivider(ref0_predivider), .ref1_predivider(ref1_predivider),
    .ref0_feedback_divider(ref0_feedback_divider),
    .ref1_feedback_divider(ref1_feedback_divider), .active_predivider(active_predivider),
    .active_feedback_divider(active_feedback_divider), .selected_ref(selected_ref),
    .selected_ref_valid(selected_ref_valid), .pll_state(pll_state),
    .state_forced(state_forced), .locked_bandwidth(locked_bandwidth),
    .acquire_bandwidth(acquire_bandwidth), .locked_damping(locked_damping),
    .acquire_damping(acquire_damping), .loop_gain(loop_gain),
    .lock_toggle_damping(lock_toggle_damping),
    .lock_toggle_hysteresis(lock_toggle_hysteresis),
    .lock_toggle_bandwidth(lock_toggle_bandwidth),
    .lock_toggle_threshold(lock_toggle_threshold));

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // reserved bits carry no defined value, so they are masked off before comparing
  task automatic rdc(input logic [15:0] a, input logic [7:0] keep, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    u_host.rd(a, d, ok);
    chk(ok, 1'b1);
    chk(d & keep, exp);
  endtask : rdc

  // selection output lands one cycle after settings, active ratios two
  task automatic settle;
    repeat (4) @(posedge mclk);
    #1;
  endtask : settle

  task automatic t_reset;
    logic [15:0] a [17] = '{16'h0008, 16'h0009, 16'h000a, 16'h000b, 16'h000c, 16'h000d,
      16'h000e, 16'h000f, 16'h0010, 16'h0017, 16'h0018, 16'h0019, 16'h001a, 16'h001b,
      16'h001c, 16'h0023, 16'h0024};
    logic [7:0] m [17] = '{8'he0, 8'h0f, 8'h33, 8'h1f, 8'hff, 8'hff, 8'h1f, 8'hff, 8'hff,
      8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
    logic [7:0] e [17] = '{8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h07, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h77, 8'h6c};
    chk(pll_state, PRFC_ST_FREE_RUNNING_STATE);
    chk(state_forced, 1'b0);
    for (int i = 0; i < 17; i++) begin
      rdc(a[i], m[i], e[i]);
    end
    rdc(16'h0025, 8'hfe, 8'h00);
    rdc(16'h0028, 8'hfe, 8'h00);
  endtask : t_reset

  task automatic t_ratios;
    u_host.wr(16'h000b, 8'h15, 8'h1f);
    u_host.wr(16'h000c, 8'h5a, 8'hff);
    u_host.wr(16'h000d, 8'ha5, 8'hff);
    u_host.wr(16'h000e, 8'h1f, 8'h1f);
    u_host.wr(16'h000f, 8'hff, 8'hff);
    u_host.wr(16'h0010, 8'hff, 8'hff);
    for (int i = 0; i < 3; i++) begin
      u_host.wr(16'h0017 + 16'(i), FB0[23-8*i -: 8], 8'hff);
      u_host.wr(16'h001a + 16'(i), FB1[23-8*i -: 8], 8'hff);
    end
    #1;
    chk(ref0_predivider, 21'h15_5aa5);
    chk(ref1_predivider, 21'h1f_ffff);
    chk(ref0_feedback_divider, FB0);
    chk(ref1_feedback_divider, FB1);
    rdc(16'h0017, 8'hff, 8'ha5);
    rdc(16'h001c, 8'hff, 8'h80);
  endtask : t_ratios

  task automatic sel_chk(input logic r, input logic v, input logic [23:0] fb);
    settle();
    chk(selected_ref, r);
    chk(selected_ref_valid, v);
    chk(active_feedback_divider, fb);
    chk(active_predivider, r ? 21'h1f_ffff : 21'h15_5aa5);
  endtask : sel_chk

  task automatic t_select;
    @(posedge mclk);
    ref0_valid <= 1'b1;
    ref1_valid <= 1'b1;
    u_host.wr(16'h0009, 8'h01, 8'h0f);
    sel_chk(1'b1, 1'b1, FB1);
    u_host.wr(16'h000a, 8'h20, 8'h33);
    sel_chk(1'b0, 1'b1, FB0);
    u_host.wr(16'h000a, 8'h10, 8'h33);
    sel_chk(1'b1, 1'b1, FB1);
    u_host.wr(16'h000a, 8'h00, 8'h33);
    u_host.wr(16'h0009, 8'h04, 8'h0f);
    sel_chk(1'b0, 1'b1, FB0);
    @(posedge mclk);
    ref0_valid <= 1'b0;
    sel_chk(1'b1, 1'b1, FB1);
    // manual modes ignore priority: gpio picks ref1 although ref0 ranks first
    @(posedge mclk);
    ref0_valid <= 1'b1;
    gpio_ref_select <= 1'b1;
    u_host.wr(16'h0008, 8'h20, 8'he0);
    sel_chk(1'b1, 1'b1, FB1);
    u_host.wr(16'h0008, 8'ha0, 8'he0);
    sel_chk(1'b1, 1'b1, FB1);
    // exclusion has no say outside automatic mode
    u_host.wr(16'h000a, 8'h10, 8'h33);
    u_host.wr(16'h0008, 8'h80, 8'he0);
    sel_chk(1'b0, 1'b1, FB0);
    u_host.wr(16'h000a, 8'h00, 8'h33);
    // reserved mode keeps the last pick but reports it unusable
    u_host.wr(16'h0008, 8'h40, 8'he0);
    sel_chk(1'b0, 1'b0, FB0);
    u_host.wr(16'h0008, 8'h00, 8'he0);
  endtask : t_select

  task automatic t_override;
    prfc_state_e st [4] = '{PRFC_ST_NORMAL, PRFC_ST_FREE_RUNNING_STATE, PRFC_ST_NORMAL, PRFC_ST_HOLDOVER};
    for (int c = 1; c < 4; c++) begin
      u_host.wr(16'h000a, 8'(c), 8'h33);
      settle();
      chk(pll_state, st[c]);
      chk(state_forced, 1'b1);
    end
    u_host.wr(16'h000a, 8'h00, 8'h33);
    settle();
    chk(pll_state, st[0]);
    chk(state_forced, 1'b0);
    @(posedge mclk);
    ref0_valid <= 1'b0;
    ref1_valid <= 1'b0;
    settle();
    chk(pll_state, PRFC_ST_HOLDOVER);
  endtask : t_override

  task automatic t_loop;
    u_host.wr(16'h0023, 8'h3c, 8'hff);
    u_host.wr(16'h0024, 8'h9e, 8'hff);
    #1;
    chk({locked_bandwidth, acquire_bandwidth}, 8'h3c);
    chk({locked_damping, acquire_damping, loop_gain}, {3'h4, 3'h7, 2'h2});
    rdc(16'h0024, 8'hff, 8'h9e);
    u_host.wr(16'h0025, 8'hb5, 8'hfe);
    u_host.wr(16'h0028, 8'h93, 8'hfe);
    #1;
    chk({lock_toggle_damping, lock_toggle_hysteresis, lock_toggle_bandwidth}, 7'h5a);
    chk(lock_toggle_threshold, 7'h49);
    rdc(16'h0028, 8'hfe, 8'h92);
  endtask : t_loop

  task automatic end_sim;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  initial begin
    #200000;
    n_mismatch++;
    end_sim();
  end

  initial begin
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    t_reset();
    t_ratios();
    t_select();
    t_loop();
    t_override();
    end_sim();
  end
endmodule : prfc_config_regs_tb
